// *** inc/alsu_pkg.sv ***
// constants for the accumulator arithmetic, logic and shift unit
package alsu_pkg;
	// timing, in the units the times are given in
	localparam int CLK_MHZ = 25;
	localparam int T_STA_NS = 3400;
	localparam int T_IRS_NS = 5100;
	// least times round up to whole cycles
	localparam logic [7:0] CYC_STA = 8'((T_STA_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] CYC_IRS = 8'((T_IRS_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] CYC_MIN = 8'h01;
	// instruction word fields, bit 1 of the word is index 15
	localparam int OP_MSB = 13;
	localparam int OP_LSB = 10;
	localparam int SH_MSB = 15;
	localparam int SH_LSB = 6;
	localparam int CNT_MSB = 5;
	// memory reference opcodes and the shift class opcode
	localparam logic [3:0] OP_SHIFT_CLASS = 4'h0;
	localparam logic [3:0] OP_AND = 4'h3;
	localparam logic [3:0] OP_STORE = 4'h4;
	localparam logic [3:0] OP_XOR = 4'h5;
	localparam logic [3:0] OP_ADD = 4'h6;
	localparam logic [3:0] OP_SUB = 4'h7;
	localparam logic [3:0] OP_INC_SKIP = 4'hA;
	localparam logic [3:0] OP_MUL = 4'hE;
	localparam logic [3:0] OP_DIV = 4'hF;
	// shift codes, instruction bits 1 to 10
	localparam logic [9:0] SH_LOG_LEFT = 10'h10C;
	localparam logic [9:0] SH_LOG_RIGHT = 10'h108;
	localparam logic [9:0] SH_ROT_LEFT = 10'h10E;
	localparam logic [9:0] SH_ROT_RIGHT = 10'h10A;
	// register byte offsets
	localparam logic [4:0] OFS_ACC = 5'h00;
	localparam logic [4:0] OFS_EXT = 5'h04;
	localparam logic [4:0] OFS_CTRL = 5'h08;
	localparam logic [4:0] OFS_ISTAT = 5'h0C;
	localparam logic [4:0] OFS_IMASK = 5'h10;
	// control register fields
	localparam int CTRL_CARRY = 0;
	localparam int CTRL_BUSY = 1;
	// interrupt status fields
	localparam int IRQ_DONE = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_SKIP = 2;
	// reset values
	localparam logic [15:0] ACC_RST = 16'h0000;
	localparam logic [15:0] EXT_RST = 16'h0000;
	localparam logic [2:0] IMASK_RST = 3'h0;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_READ = 3'h1,
		S_WRITE = 3'h2,
		S_SHIFT = 3'h3,
		S_PAD = 3'h4
	} alsu_state_t;
	typedef enum logic [1:0] {
		SK_LL = 2'h0,
		SK_LR = 2'h1,
		SK_RL = 2'h2,
		SK_RR = 2'h3
	} alsu_shift_t;
endpackage

// *** hw/alsu_core.sv ***
// accumulator arithmetic, logic and shift unit with avalon register slave
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - store accumulator writes all sixteen bits to memory, accumulator kept, 3.4 us.
// - add operand to accumulator, carry flag set on overflow else cleared.
// - divide accumulator and extension low fifteen, quotient to acc, remainder to ext.
// - divide flags overflow when accumulator magnitude not below divisor, one exception.
// - increment memory word, write back, skip next when result is zero, 5.1 us.
// - signed multiply, high part to accumulator, low to extension, no overflow.
// - subtract operand from accumulator, carry flag set on overflow else cleared.
// - logical product clears accumulator bits where operand bit is zero.
// - logical difference inverts accumulator bits where operand bit is one.
// - shift count is two's complement of low six bits, every step performed.
// - logical left shift fills zeros, each outgoing bit into the carry.
// - logical right shift fills zeros at top, each outgoing bit into carry.
// - rotate left moves top bit to bottom, outgoing bit copied to carry.
// - rotate right moves bottom bit to top, outgoing bit copied to carry.
// - overflow lamp follows the carry flag at the end of each instruction.
// - opcode in bits 3 to 6, shift code in bits 1 to 10.
// - bit 1 is the most significant sign bit in every word.
module alsu_core
	import alsu_pkg::*;
#(
	parameter int ADDR_W = 14
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	// avalon register slave
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// instruction issue from fetch and addressing
	input wire logic EXEC_START,
	input wire logic [15:0] EXEC_INSTR,
	input wire logic [ADDR_W-1:0] EXEC_EADDR,
	output logic EXEC_BUSY,
	output logic EXEC_DONE,
	output logic EXEC_SKIP,
	// operand memory
	output logic [ADDR_W-1:0] MEM_ADDR,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic [15:0] MEM_WDATA,
	input wire logic [15:0] MEM_RDATA,
	input wire logic MEM_ACK,
	// status
	output logic C_LAMP,
	output logic IRQ
);
	if (ADDR_W < 9 || ADDR_W > 16) begin : g_chk
		$error("ADDR_W must lie between 9 and 16");
	end

	typedef struct packed {
		alsu_state_t st;
		alsu_shift_t sk;
		logic [3:0] op;
		logic [15:0] a;
		logic [15:0] b;
		logic c;
		logic cmod;
		logic lamp;
		logic [ADDR_W-1:0] ea;
		logic [15:0] mdat;
		logic [5:0] cnt;
		logic [7:0] elap;
		logic [7:0] minc;
		logic busy;
		logic done;
		logic skip;
		logic rd;
		logic wr;
		logic [2:0] ist;
		logic [2:0] imask;
		logic irq;
		logic wait_r;
		logic [31:0] rdata;
	} alsu_regs_t;

	alsu_regs_t r;
	alsu_regs_t n;

	// arithmetic on the operand just read; bit 15 is the sign
	logic [15:0] m;
	logic [15:0] sum;
	logic [15:0] diff;
	logic add_ovf;
	logic sub_ovf;
	logic [31:0] prod;
	logic [30:0] dvd;
	logic [30:0] dmag;
	logic [15:0] amag;
	logic [15:0] mmag;
	logic [30:0] dsor;
	logic [30:0] quo;
	logic [30:0] rem;
	logic div_ovf;
	logic [15:0] quo_s;
	logic [14:0] rem_s;
	logic [15:0] inc;
	logic req;
	logic wr_go;
	logic [2:0] ev;

	assign m = MEM_RDATA;
	assign sum = r.a + m;
	assign diff = r.a - m;
	assign add_ovf = (r.a[15] == m[15]) && (sum[15] != r.a[15]);
	assign sub_ovf = (r.a[15] != m[15]) && (diff[15] != r.a[15]);
	assign prod = $signed(r.a) * $signed(m);
	assign dvd = {r.a, r.b[14:0]};
	assign dmag = dvd[30] ? 31'(31'h0000 - dvd) : dvd;
	assign amag = r.a[15] ? 16'(16'h0000 - r.a) : r.a;
	assign mmag = m[15] ? 16'(16'h0000 - m) : m;
	// zero divisor is flagged below; the guard only keeps the divider defined
	assign dsor = (mmag == 16'h0000) ? 31'h0000_0001 : {15'h0000, mmag};
	assign quo = dmag / dsor;
	assign rem = dmag % dsor;
	assign div_ovf = (amag >= mmag)
		&& !(r.a[15] && !m[15] && (amag == mmag));
	assign quo_s = (r.a[15] ^ m[15]) ? 16'(16'h0000 - quo[15:0]) : quo[15:0];
	assign rem_s = dvd[30] ? 15'(15'h0000 - rem[14:0]) : rem[14:0];
	assign inc = m + 16'h0001;
	assign req = AVS_READ || AVS_WRITE;
	assign wr_go = AVS_WRITE && !r.wait_r;

	always_comb begin
		n = r;
		n.done = 1'b0;
		n.skip = 1'b0;
		ev = 3'h0;
		if (r.busy && r.elap != 8'hFF) begin
			n.elap = r.elap + 8'h01;
		end
		unique case (r.st)
			S_IDLE: begin
				if (EXEC_START) begin
					n.busy = 1'b1;
					n.elap = 8'h01;
					n.ea = EXEC_EADDR;
					n.op = EXEC_INSTR[OP_MSB:OP_LSB];
					n.minc = CYC_MIN;
					n.cmod = 1'b0;
					// the count field holds the negated count
					n.cnt = 6'(6'h00 - EXEC_INSTR[CNT_MSB:0]);
					if (EXEC_INSTR[OP_MSB:OP_LSB] == OP_SHIFT_CLASS) begin
						n.cmod = 1'b1;
						n.st = S_SHIFT;
						unique case (EXEC_INSTR[SH_MSB:SH_LSB])
							SH_LOG_LEFT: n.sk = SK_LL;
							SH_LOG_RIGHT: n.sk = SK_LR;
							SH_ROT_LEFT: n.sk = SK_RL;
							SH_ROT_RIGHT: n.sk = SK_RR;
							default: begin
								n.cmod = 1'b0;
								n.st = S_PAD;
							end
						endcase
					end else if (EXEC_INSTR[OP_MSB:OP_LSB] == OP_STORE) begin
						n.mdat = r.a;
						n.wr = 1'b1;
						n.minc = CYC_STA;
						n.st = S_WRITE;
					end else begin
						if (EXEC_INSTR[OP_MSB:OP_LSB] == OP_INC_SKIP) begin
							n.minc = CYC_IRS;
						end
						n.rd = 1'b1;
						n.st = S_READ;
					end
				end
			end
			S_READ: begin
				// accumulator, extension and carry hold until the operand has arrived
				if (MEM_ACK) begin
					n.rd = 1'b0;
					n.st = S_PAD;
					unique case (r.op)
						OP_ADD: begin
							n.a = sum;
							n.c = add_ovf;
							n.cmod = 1'b1;
						end
						OP_SUB: begin
							n.a = diff;
							n.c = sub_ovf;
							n.cmod = 1'b1;
						end
						OP_AND: n.a = r.a & m;
						OP_XOR: n.a = r.a ^ m;
						OP_MUL: begin
							n.a = prod[30:15];
							n.b = {1'b0, prod[14:0]};
						end
						OP_DIV: begin
							n.c = div_ovf;
							n.cmod = 1'b1;
							// an illegal divide leaves both registers as they were
							if (!div_ovf) begin
								n.a = quo_s;
								n.b = {1'b0, rem_s};
							end
						end
						OP_INC_SKIP: begin
							n.mdat = inc;
							n.wr = 1'b1;
							n.st = S_WRITE;
						end
						default: n.st = S_PAD;
					endcase
				end
			end
			S_WRITE: begin
				if (MEM_ACK) begin
					n.wr = 1'b0;
					n.st = S_PAD;
				end
			end
			S_SHIFT: begin
				// one position per clock, so large counts still take every step
				if (r.cnt == 6'h00) begin
					n.st = S_PAD;
				end else begin
					n.cnt = r.cnt - 6'h01;
					unique case (r.sk)
						SK_LL: begin
							n.c = r.a[15];
							n.a = {r.a[14:0], 1'b0};
						end
						SK_LR: begin
							n.c = r.a[0];
							n.a = {1'b0, r.a[15:1]};
						end
						SK_RL: begin
							n.c = r.a[15];
							n.a = {r.a[14:0], r.a[15]};
						end
						SK_RR: begin
							n.c = r.a[0];
							n.a = {r.a[0], r.a[15:1]};
						end
					endcase
				end
			end
			S_PAD: begin
				if (r.elap >= r.minc) begin
					n.st = S_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
					n.lamp = r.c;
					n.skip = (r.op == OP_INC_SKIP) && (r.mdat == 16'h0000);
					ev[IRQ_DONE] = 1'b1;
					ev[IRQ_OVF] = r.cmod && r.c;
					ev[IRQ_SKIP] = n.skip;
				end
			end
			default: begin
				n.st = S_IDLE;
				n.busy = 1'b0;
			end
		endcase
		// avalon slave: one wait cycle, then answer
		n.wait_r = !(req && r.wait_r);
		if (AVS_READ && r.wait_r) begin
			unique case (AVS_ADDRESS)
				OFS_ACC: n.rdata = {16'h0000, r.a};
				OFS_EXT: n.rdata = {16'h0000, r.b};
				OFS_CTRL: n.rdata = {30'h0000_0000, r.busy, r.c};
				OFS_ISTAT: n.rdata = {29'h0000_0000, r.ist};
				OFS_IMASK: n.rdata = {29'h0000_0000, r.imask};
				default: n.rdata = 32'h0000_0000;
			endcase
		end
		// software may load acc, ext and ctrl only while no instruction runs
		if (wr_go && !r.busy) begin
			if (AVS_ADDRESS == OFS_ACC) begin
				n.a = AVS_WRITEDATA[15:0];
			end
			if (AVS_ADDRESS == OFS_EXT) begin
				n.b = AVS_WRITEDATA[15:0];
			end
			if (AVS_ADDRESS == OFS_CTRL) begin
				n.c = AVS_WRITEDATA[CTRL_CARRY];
				n.lamp = AVS_WRITEDATA[CTRL_CARRY];
			end
		end
		if (wr_go && AVS_ADDRESS == OFS_IMASK) begin
			n.imask = AVS_WRITEDATA[2:0];
		end
		// a new event wins over a clear in the same cycle
		n.ist = r.ist | ev;
		if (wr_go && AVS_ADDRESS == OFS_ISTAT) begin
			n.ist = (r.ist & ~AVS_WRITEDATA[2:0]) | ev;
		end
		n.irq = |(n.ist & n.imask);
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			r <= '{st: S_IDLE, sk: SK_LL, op: 4'h0, a: ACC_RST, b: EXT_RST,
				c: 1'b0, cmod: 1'b0, lamp: 1'b0, ea: '0, mdat: 16'h0000,
				cnt: 6'h00, elap: 8'h00, minc: 8'h00, busy: 1'b0,
				done: 1'b0, skip: 1'b0, rd: 1'b0, wr: 1'b0, ist: 3'h0,
				imask: IMASK_RST, irq: 1'b0, wait_r: 1'b1,
				rdata: 32'h0000_0000};
		end else begin
			r <= n;
		end
	end

	assign AVS_READDATA = r.rdata;
	assign AVS_WAITREQUEST = r.wait_r;
	assign EXEC_BUSY = r.busy;
	assign EXEC_DONE = r.done;
	assign EXEC_SKIP = r.skip;
	assign MEM_ADDR = r.ea;
	assign MEM_RD = r.rd;
	assign MEM_WR = r.wr;
	assign MEM_WDATA = r.mdat;
	assign C_LAMP = r.lamp;
	assign IRQ = r.irq;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);

	a_store_acc_data: assert property (r.st == S_WRITE && r.op == OP_STORE
		|-> MEM_WDATA == r.a)
		else $error("store data differs from accumulator");
	a_store_min_time: assert property (r.done && r.op == OP_STORE
		|-> $past(r.elap) >= CYC_STA)
		else $error("store finished too early");
	a_add_sum_flag: assert property (r.st == S_READ && MEM_ACK && r.op == OP_ADD
		|=> r.a == 16'($past(r.a) + $past(MEM_RDATA))
		&& r.c == ($past(r.a[15]) == $past(MEM_RDATA[15])
		&& r.a[15] != $past(r.a[15])))
		else $error("add result or flag wrong");
	a_div_ext_clear: assert property (r.st == S_READ && MEM_ACK && r.op == OP_DIV
		&& !div_ovf |=> !r.b[15] && !r.c)
		else $error("divide left extension sign or flag set");
	a_div_ovf_keep: assert property (r.st == S_READ && MEM_ACK && r.op == OP_DIV
		&& amag > mmag |=> r.c && $stable(r.a))
		else $error("illegal divide not flagged");
	a_inc_skip_zero: assert property (r.st == S_READ && MEM_ACK
		&& r.op == OP_INC_SKIP && MEM_RDATA == 16'hFFFF
		|-> ##[1:200] EXEC_SKIP)
		else $error("increment to zero did not skip");
	a_mul_no_flag: assert property (r.st == S_READ && MEM_ACK && r.op == OP_MUL
		|=> $stable(r.c) && !r.b[15])
		else $error("multiply touched carry or extension sign");
	a_sub_diff: assert property (r.st == S_READ && MEM_ACK && r.op == OP_SUB
		|=> r.a == 16'($past(r.a) - $past(MEM_RDATA)))
		else $error("subtract result wrong");
	a_and_clear: assert property (r.st == S_READ && MEM_ACK && r.op == OP_AND
		|=> r.a == ($past(r.a) & $past(MEM_RDATA)))
		else $error("logical product wrong");
	a_xor_invert: assert property (r.st == S_READ && MEM_ACK && r.op == OP_XOR
		|=> r.a == ($past(r.a) ^ $past(MEM_RDATA)))
		else $error("logical difference wrong");
	a_shift_step_count: assert property (r.st == S_SHIFT && r.cnt != 6'h00
		|=> r.st == S_SHIFT && r.cnt == 6'($past(r.cnt) - 6'h01))
		else $error("shift step count wrong");
	a_left_shift_fill: assert property (r.st == S_SHIFT && r.cnt != 6'h00
		&& r.sk == SK_LL |=> r.a == {$past(r.a[14:0]), 1'b0}
		&& r.c == $past(r.a[15]))
		else $error("left shift step wrong");
	a_rot_right_wrap: assert property (r.st == S_SHIFT && r.cnt != 6'h00
		&& r.sk == SK_RR |=> r.a[15] == $past(r.a[0])
		&& r.c == $past(r.a[0]))
		else $error("rotate right step wrong");
	a_lamp_follows: assert property (EXEC_DONE |-> C_LAMP == r.c)
		else $error("lamp differs from carry at end");
	a_read_holds_acc: assert property (r.st == S_READ && !MEM_ACK
		|=> $stable(r.a) && $stable(r.c))
		else $error("register changed before operand arrived");
	a_bus_answer: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request not answered in one cycle");

	c_store_done: cover property (r.done && r.op == OP_STORE);
	c_skip_taken: cover property (EXEC_SKIP);
	c_long_shift: cover property (r.st == S_SHIFT && r.cnt == 6'h3F);
	c_div_illegal: cover property (r.st == S_READ && MEM_ACK
		&& r.op == OP_DIV && div_ovf);
endmodule

`default_nettype wire

// *** bench/alsu_mem_model.sv ***
// behavioural operand memory answering after a programmable wait
`timescale 1ns/1ns
`default_nettype none
module alsu_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// request
	input wire logic [13:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [15:0] wdata,
	input wire logic [3:0] dly,
	// answer
	output logic [15:0] rdata,
	output logic ack
);
	logic [15:0] mem [16];
	logic [3:0] wait_r;
	// rdata toggles outside the ack cycle so a late sample never matches by luck
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			wait_r <= 4'h0;
			rdata <= 16'h5a5a;
		end else begin
			ack <= 1'b0;
			rdata <= ~rdata;
			if ((rd || wr) && !ack) begin
				if (wait_r >= dly) begin
					ack <= 1'b1;
					wait_r <= 4'h0;
					if (rd)
						rdata <= mem[addr[3:0]];
					if (wr)
						mem[addr[3:0]] <= wdata;
				end else begin
					wait_r <= wait_r + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the arithmetic, logic and shift unit
`timescale 1ns/1ns
`default_nettype none
module tb;
	import alsu_pkg::*;
	logic clk, rst_b, avs_read, avs_write, exec_start, c_exp;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, lfsr;
	logic avs_waitrequest, exec_busy, exec_done, exec_skip;
	logic [15:0] exec_instr, mem_wdata, mem_rdata, a, m;
	logic [13:0] exec_eaddr, mem_addr;
	logic mem_rd, mem_wr, mem_ack, c_lamp, irq;
	logic [3:0] dly;
	logic [16:0] r;
	logic signed [31:0] p;
	logic [31:0] rd_q[$];
	logic [1:0] done_q[$];
	logic [9:0] codes[4] = '{SH_LOG_LEFT, SH_LOG_RIGHT, SH_ROT_LEFT, SH_ROT_RIGHT};
	int failures, n_compared, cyc, n;

	alsu_core uut (.REF_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.EXEC_START(exec_start), .EXEC_INSTR(exec_instr), .EXEC_EADDR(exec_eaddr),
		.EXEC_BUSY(exec_busy), .EXEC_DONE(exec_done), .EXEC_SKIP(exec_skip),
		.MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
		.MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack),
		.C_LAMP(c_lamp), .IRQ(irq));
	alsu_mem_model u_mem (.clk(clk), .rst_b(rst_b), .addr(mem_addr),
		.rd(mem_rd), .wr(mem_wr), .wdata(mem_wdata), .dly(dly),
		.rdata(mem_rdata), .ack(mem_ack));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] o(input logic [3:0] x);
		return {2'b00, x, 10'h000};
	endfunction
	// per-step reference, so saturation and wrap fall out of the step count
	function automatic logic [16:0] shf(input int k, input logic [15:0] v,
		input int cnt, input logic c);
		for (int i = 0; i < cnt; i++) begin
			case (k)
				0: begin c = v[15]; v = {v[14:0], 1'b0}; end
				1: begin c = v[0]; v = {1'b0, v[15:1]}; end
				2: begin c = v[15]; v = {v[14:0], v[15]}; end
				default: begin c = v[0]; v = {v[0], v[15:1]}; end
			endcase
		end
		return {c, v};
	endfunction

	task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_flags(input logic [1:0] g, input logic [1:0] e);
		cmp_word({30'h0, g}, {30'h0, e});
	endtask
	task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= ad;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// waitrequest is judged at the rising edge, where the answer is taken
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50)
			failures++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// one idle edge keeps two strobes from meeting in one time step
		@(posedge clk);
	endtask
	task automatic rd(input logic [4:0] ad, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, ad, 32'h0);
	endtask
	task automatic seta(input logic [15:0] v);
		bus(1'b1, OFS_ACC, {16'h0, v});
	endtask
	task automatic chk_irq(input logic e);
		repeat (2) @(negedge clk);
		cmp_flags({1'b0, irq}, {1'b0, e});
		@(posedge clk);
	endtask
	// expected skip and lamp are noted before the start pulse
	task automatic run(input logic [15:0] ins, input logic [13:0] ea,
		input logic [1:0] e);
		done_q.push_back(e);
		exec_instr <= ins;
		exec_eaddr <= ea;
		exec_start <= 1'b1;
		dly <= lfsr[3:0] & 4'h3;
		lfsr = nxt(lfsr);
		@(posedge clk);
		exec_start <= 1'b0;
		cyc = 0;
		do begin
			@(negedge clk);
			cyc++;
			if (cyc == 1)
				cmp_flags({1'b0, exec_busy}, 2'b01);
		end while (exec_done !== 1'b1 && cyc < 400);
		if (exec_done !== 1'b1)
			failures++;
		cmp_flags({1'b0, exec_busy}, 2'b00);
		@(posedge clk);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// read data is taken at the rising edge that sees waitrequest low
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0)
			cmp_word(avs_readdata, rd_q.pop_front());
	end
	always @(negedge clk) begin
		if (exec_done === 1'b1)
			cmp_flags({exec_skip, c_lamp}, done_q.pop_front());
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up();
	end

	initial begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		exec_start = 1'b0;
		exec_instr = 16'h0;
		exec_eaddr = 14'h0;
		dly = 4'h0;
		lfsr = 32'h0000_ac07;
		failures = 0;
		n_compared = 0;
		u_mem.mem[1] = 16'h0001;
		u_mem.mem[2] = 16'h3c3c;
		u_mem.mem[3] = 16'h0000;
		u_mem.mem[4] = 16'hffff;
		u_mem.mem[5] = 16'h0005;
		u_mem.mem[6] = 16'h0007;
		u_mem.mem[7] = 16'h0003;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(OFS_ACC, 32'h0);
		rd(OFS_IMASK, 32'h0);
		rd(5'h14, 32'h0);
		seta(16'h8001);
		run(o(OP_STORE), 14'd3, 2'b00);
		cmp_word(32'(cyc >= int'(CYC_STA)), 32'h1);
		cmp_word({16'h0, u_mem.mem[3]}, 32'h8001);
		rd(OFS_ACC, 32'h8001);
		seta(16'h7fff);
		bus(1'b1, OFS_ISTAT, 32'h7);
		run(o(OP_ADD), 14'd1, 2'b01);
		rd(OFS_ACC, 32'h8000);
		rd(OFS_ISTAT, 32'h3);
		chk_irq(1'b0);
		bus(1'b1, OFS_IMASK, 32'h2);
		chk_irq(1'b1);
		bus(1'b1, OFS_ISTAT, 32'h2);
		chk_irq(1'b0);
		rd(OFS_ISTAT, 32'h1);
		seta(16'hf0f0);
		run(o(OP_AND), 14'd2, 2'b01);
		rd(OFS_ACC, 32'h3030);
		run(o(OP_XOR), 14'd2, 2'b01);
		rd(OFS_ACC, 32'h0c0c);
		cmp_word({16'h0, u_mem.mem[2]}, 32'h3c3c);
		seta(16'h8000);
		run(o(OP_SUB), 14'd1, 2'b01);
		rd(OFS_ACC, 32'h7fff);
		run(o(OP_SUB), 14'd1, 2'b00);
		rd(OFS_ACC, 32'h7ffe);
		for (int i = 0; i < 4; i++) begin
			a = lfsr[15:0];
			m = lfsr[31:16];
			lfsr = nxt(lfsr);
			u_mem.mem[8] = m;
			p = $signed(a) * $signed(m);
			seta(a);
			run(o(OP_MUL), 14'd8, 2'b00);
			rd(OFS_ACC, {16'h0, p[30:15]});
			rd(OFS_EXT, {17'h0, p[14:0]});
		end
		seta(16'h0000);
		bus(1'b1, OFS_EXT, 32'h64);
		run(o(OP_DIV), 14'd6, 2'b00);
		rd(OFS_ACC, 32'h000e);
		rd(OFS_EXT, 32'h0002);
		seta(16'h0005);
		run(o(OP_DIV), 14'd7, 2'b01);
		rd(OFS_ACC, 32'h0005);
		seta(16'hfffd);
		bus(1'b1, OFS_EXT, 32'h0);
		run(o(OP_DIV), 14'd7, 2'b00);
		rd(OFS_ACC, 32'h8000);
		bus(1'b1, OFS_ISTAT, 32'h7);
		run(o(OP_INC_SKIP), 14'd4, 2'b10);
		cmp_word(32'(cyc >= int'(CYC_IRS)), 32'h1);
		cmp_word({16'h0, u_mem.mem[4]}, 32'h0);
		rd(OFS_ISTAT, 32'h5);
		run(o(OP_INC_SKIP), 14'd5, 2'b00);
		cmp_word({16'h0, u_mem.mem[5]}, 32'h6);
		bus(1'b1, OFS_CTRL, 32'h0);
		c_exp = 1'b0;
		// a missing or extra step shows up as a wrong value or carry, unless a logical shift has already cleared both
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 3; j++) begin
				a = lfsr[15:0];
				lfsr = nxt(lfsr);
				n = (j == 0) ? 1 : (j == 1) ? 17 : 63;
				r = shf(k, a, n, c_exp);
				seta(a);
				run({codes[k], 6'(64 - n)}, 14'd0, {1'b0, r[16]});
				rd(OFS_ACC, {16'h0, r[15:0]});
				c_exp = r[16];
			end
		end
		wrap_up();
	end
endmodule
`default_nettype wire
